// [core/omvc_top.v]
// output mixer and speaker volume control with serial register port
// Operation
// - speaker mixer bit 5 selects aux source
// - speaker mixer bit 1 selects bypass path
// - speaker mixer bit 0 selects dac, combinable
// - volume bit 8 sets bypass attenuation -10dB
// - negative speaker output is inverted positive
// - mute resets set, holds reference level
// - zero-cross bit defers gain, else immediate
// - six-bit gain, 1dB steps, -57 to +6
// - timeout applies pending gain, needs slow clock
// - additional control bit 0 enables slow clock
// - mono mixer bits 2,1,0 select sources
// - mono bit 7 sets bypass attenuation
// - mono silence drives mid reference level
// - mono output drives only when enabled
// - slow clock divides master by 2^21
`timescale 1ns/100ps
`include "omvc_defs.vh"
module omvc_top #(
  parameter [31:0] SLOW_DIV = `OMVC_SLOW_DIV
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // serial control port, sampled on ref_clk
  input  wire        ctl_sclk,
  input  wire        ctl_sdin,
  input  wire        ctl_csb,
  // mono output enable from power control
  input  wire        mono_out_enable,
  // source samples
  input  wire        sample_valid,
  input  wire [15:0] dac_sample,
  input  wire [15:0] bypass_sample,
  input  wire [15:0] aux_sample,
  // outputs
  output reg         out_valid,
  output reg  [15:0] speaker_pos_out,
  output reg  [15:0] speaker_neg_out,
  output reg  [15:0] mono_line_out,
  // status
  output reg  [5:0]  speaker_gain_now,
  output reg         speaker_gain_pending
);

  // ---------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------
  function [15:0] omvc_sat16;
    input signed [35:0] v;
    begin
      if (v > $signed(`OMVC_POS_MAX))
        omvc_sat16 = `OMVC_OUT_MAX;
      else if (v < $signed(`OMVC_NEG_MIN))
        omvc_sat16 = `OMVC_OUT_MIN;
      else
        omvc_sat16 = v[15:0];
    end
  endfunction

  function signed [35:0] omvc_ext;
    input [15:0] x;
    begin
      omvc_ext = {{20{x[15]}}, x};
    end
  endfunction

  // bypass contribution, optionally cut by about 10 dB
  function signed [35:0] omvc_bypass;
    input [15:0] x;
    input        atten;
    reg signed [35:0] p;
    begin
      p = omvc_ext(x) * $signed(`OMVC_ATTN_MULT);
      if (atten)
        omvc_bypass = p >>> `OMVC_Q_SHIFT;
      else
        omvc_bypass = omvc_ext(x);
    end
  endfunction

  // three-source mixer; the caller saturates the wide sum once, after all sources add
  function signed [35:0] omvc_mix;
    input [15:0] aux;
    input [15:0] byp;
    input [15:0] dac;
    input        aux_sel;
    input        byp_sel;
    input        dac_sel;
    input        atten;
    reg signed [35:0] sum;
    begin
      sum = 36'h0_0000_0000;
      if (aux_sel)
        sum = sum + omvc_ext(aux);
      if (byp_sel)
        sum = sum + omvc_bypass(byp, atten);
      if (dac_sel)
        sum = sum + omvc_ext(dac);
      omvc_mix = sum;
    end
  endfunction

  // two's complement negate; the 0x8000 corner clips to full positive
  function [15:0] omvc_neg16;
    input [15:0] x;
    begin
      if (x == `OMVC_OUT_MIN)
        omvc_neg16 = `OMVC_OUT_MAX;
      else
        omvc_neg16 = 16'h0000 - x;
    end
  endfunction

  // one step per code; code 0x39 is unity gain
  function [15:0] omvc_gain;
    input [15:0] x;
    input [5:0]  code;
    reg   [6:0]  n;
    reg   [6:0]  oct;
    reg   [6:0]  frac;
    reg   [8:0]  m;
    reg signed [35:0] p;
    begin
      n    = {1'b0, code} + `OMVC_GAIN_OFFSET;
      oct  = n / `OMVC_STEPS_PER_OCT;
      frac = n % `OMVC_STEPS_PER_OCT;
      case (frac[2:0])
        3'h0:    m = `OMVC_STEP0;
        3'h1:    m = `OMVC_STEP1;
        3'h2:    m = `OMVC_STEP2;
        3'h3:    m = `OMVC_STEP3;
        3'h4:    m = `OMVC_STEP4;
        default: m = `OMVC_STEP5;
      endcase
      p = omvc_ext(x) * $signed({27'h000_0000, m});
      p = p <<< oct[3:0];
      omvc_gain = omvc_sat16(p >>> `OMVC_GAIN_SHIFT);
    end
  endfunction

  // ---------------------------------------------------------------
  // reset release through two flops
  // ---------------------------------------------------------------
  // release is delayed two edges so every flop reset by rst_sync_b leaves reset on the same edge
  reg rst_meta_q;
  reg rst_sync_b;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // serial control port: 16 bits shifted on sclk rise, taken on csb rise
  // ---------------------------------------------------------------
  reg        sclk_last_q;
  reg        csb_last_q;
  reg [15:0] shift_q;
  reg [4:0]  nbits_q;
  reg        wr_q;
  reg [6:0]  wr_addr_q;
  reg [8:0]  wr_data_q;

  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sclk_last_q <= 1'b0;
      csb_last_q  <= 1'b1;
      shift_q     <= 16'h0000;
      nbits_q     <= 5'h00;
      wr_q        <= 1'b0;
      wr_addr_q   <= 7'h00;
      wr_data_q   <= 9'h000;
    end else begin
      sclk_last_q <= ctl_sclk;
      csb_last_q  <= ctl_csb;
      wr_q        <= 1'b0;
      if (!ctl_csb && ctl_sclk && !sclk_last_q) begin
        shift_q <= {shift_q[14:0], ctl_sdin};
        // the count pins at the top so an over-long frame cannot wrap back to 16
        if (nbits_q != `OMVC_NBITS_MAX)
          nbits_q <= nbits_q + 5'h01;
      end
      if (ctl_csb && !csb_last_q) begin
        // short or over-long frames are dropped rather than half applied
        if (nbits_q == `OMVC_FRAME_BITS) begin
          wr_q      <= 1'b1;
          wr_addr_q <= shift_q[15:9];
          wr_data_q <= shift_q[8:0];
        end
        nbits_q <= 5'h00;
      end else if (ctl_csb) begin
        nbits_q <= 5'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [8:0] add_ctrl_q;
  reg  [8:0] spk_mix_q;
  reg  [8:0] spk_vol_q;
  reg  [8:0] mono_mix_q;
  wire       vol_wr;

  // the gate sees the zc bit in force before this write; a word's own bit rules the next one
  assign vol_wr = wr_q && (wr_addr_q == `OMVC_ADDR_SPK_VOL);

  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      add_ctrl_q <= `OMVC_RST_ADD_CTRL;
      spk_mix_q  <= `OMVC_RST_SPK_MIX;
      spk_vol_q  <= `OMVC_RST_SPK_VOL;
      mono_mix_q <= `OMVC_RST_MONO_MIX;
    end else if (wr_q) begin
      case (wr_addr_q)
        `OMVC_ADDR_ADD_CTRL: add_ctrl_q <= wr_data_q;
        `OMVC_ADDR_SPK_MIX:  spk_mix_q  <= wr_data_q;
        `OMVC_ADDR_SPK_VOL:  spk_vol_q  <= wr_data_q;
        `OMVC_ADDR_MONO_MIX: mono_mix_q <= wr_data_q;
        default:             add_ctrl_q <= add_ctrl_q;
      endcase
    end
  end

  wire aux_to_speaker_sel    = spk_mix_q[`OMVC_AUX_SPK_BIT];
  wire bypass_to_speaker_sel = spk_mix_q[`OMVC_BYP_SPK_BIT];
  wire dac_to_speaker_sel    = spk_mix_q[`OMVC_DAC_SPK_BIT];
  wire speaker_bypass_atten  = spk_vol_q[`OMVC_SPK_ATTN_BIT];
  wire speaker_zero_cross_en = spk_vol_q[`OMVC_SPK_ZC_BIT];
  wire speaker_mute          = spk_vol_q[`OMVC_SPK_MUTE_BIT];
  wire slow_tick_enable      = add_ctrl_q[`OMVC_SLOW_EN_BIT];
  wire mono_bypass_atten     = mono_mix_q[`OMVC_MONO_ATTN_BIT];
  wire mono_silence          = mono_mix_q[`OMVC_MONO_SIL_BIT];
  wire aux_to_mono_sel       = mono_mix_q[`OMVC_AUX_MONO_BIT];
  wire bypass_to_mono_sel    = mono_mix_q[`OMVC_BYP_MONO_BIT];
  wire dac_to_mono_sel       = mono_mix_q[`OMVC_DAC_MONO_BIT];

  // ---------------------------------------------------------------
  // slow tick and gain update gate
  // ---------------------------------------------------------------
  wire       slow_tick;
  wire [5:0] gain_applied;
  wire       gain_pending;

  // the timeout only runs while the slow tick is enabled
  omvc_slow_tick #(
    .DIV          (SLOW_DIV)
  ) u_slow (
    .clk          (ref_clk),
    .rst_n        (rst_sync_b),
    .enable       (slow_tick_enable),
    .tick         (slow_tick)
  );

  // ---------------------------------------------------------------
  // stage 1: mixers
  // ---------------------------------------------------------------
  reg               mix_valid_q;
  reg  [15:0]       spk_mix_val_q;
  reg  [15:0]       mono_mix_val_q;
  reg signed [35:0] spk_sum;
  reg signed [35:0] mono_sum;

  always @* begin
    spk_sum  = omvc_mix(aux_sample, bypass_sample, dac_sample, aux_to_speaker_sel,
                        bypass_to_speaker_sel, dac_to_speaker_sel,
                        speaker_bypass_atten);
    mono_sum = omvc_mix(aux_sample, bypass_sample, dac_sample, aux_to_mono_sel,
                        bypass_to_mono_sel, dac_to_mono_sel,
                        mono_bypass_atten);
  end

  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mix_valid_q    <= 1'b0;
      spk_mix_val_q  <= `OMVC_REF_LEVEL;
      mono_mix_val_q <= `OMVC_REF_LEVEL;
    end else begin
      mix_valid_q <= sample_valid;
      if (sample_valid) begin
        spk_mix_val_q  <= omvc_sat16(spk_sum);
        mono_mix_val_q <= omvc_sat16(mono_sum);
      end
    end
  end

  // crossing is judged on the mixer output that the gain stage scales
  omvc_zero_cross u_zc (
    .clk          (ref_clk),
    .rst_n        (rst_sync_b),
    .zc_en        (speaker_zero_cross_en),
    .gain_wr      (vol_wr),
    .gain_wdata   (wr_data_q[`OMVC_SPK_GAIN_HI:`OMVC_SPK_GAIN_LO]),
    .timeout_tick (slow_tick),
    .mix_valid    (mix_valid_q),
    .mix_sign     (spk_mix_val_q[15]),
    .gain_q       (gain_applied),
    .pending_q    (gain_pending)
  );

  // ---------------------------------------------------------------
  // stage 2: speaker gain, mute and mono output
  // ---------------------------------------------------------------
  wire [15:0] spk_scaled = omvc_gain(spk_mix_val_q, gain_applied);

  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_valid            <= 1'b0;
      speaker_pos_out      <= `OMVC_REF_LEVEL;
      speaker_neg_out      <= `OMVC_REF_LEVEL;
      mono_line_out        <= `OMVC_REF_LEVEL;
      speaker_gain_now     <= `OMVC_RST_GAIN;
      speaker_gain_pending <= 1'b0;
    end else begin
      out_valid            <= mix_valid_q;
      speaker_gain_now     <= gain_applied;
      speaker_gain_pending <= gain_pending;
      if (mix_valid_q) begin
        if (speaker_mute) begin
          speaker_pos_out <= `OMVC_REF_LEVEL;
          speaker_neg_out <= `OMVC_REF_LEVEL;
        end else begin
          speaker_pos_out <= spk_scaled;
          speaker_neg_out <= omvc_neg16(spk_scaled);
        end
        if (!mono_out_enable || mono_silence)
          mono_line_out <= `OMVC_REF_LEVEL;
        else
          mono_line_out <= mono_mix_val_q;
      end
    end
  end

endmodule

// [core/omvc_defs.vh]
// register map, field positions, reset values and constants of the output mixer block
`ifndef OMVC_DEFS_VH
`define OMVC_DEFS_VH

// control word framing: 7 address bits then 9 data bits, msb first
`define OMVC_FRAME_BITS      5'h10
`define OMVC_ADDR_W          7
`define OMVC_DATA_W          9

// register addresses
`define OMVC_ADDR_ADD_CTRL   7'h07
`define OMVC_ADDR_SPK_MIX    7'h32
`define OMVC_ADDR_SPK_VOL    7'h36
`define OMVC_ADDR_MONO_MIX   7'h38

// reset values
`define OMVC_RST_ADD_CTRL    9'h000
`define OMVC_RST_SPK_MIX     9'h000
`define OMVC_RST_SPK_VOL     9'h079
`define OMVC_RST_MONO_MIX    9'h000
`define OMVC_RST_GAIN        6'h39

// additional control
`define OMVC_SLOW_EN_BIT     0
// speaker mixer select
`define OMVC_AUX_SPK_BIT     5
`define OMVC_BYP_SPK_BIT     1
`define OMVC_DAC_SPK_BIT     0
// speaker volume control
`define OMVC_SPK_ATTN_BIT    8
`define OMVC_SPK_ZC_BIT      7
`define OMVC_SPK_MUTE_BIT    6
`define OMVC_SPK_GAIN_HI     5
`define OMVC_SPK_GAIN_LO     0
// mono mixer select
`define OMVC_MONO_ATTN_BIT   7
`define OMVC_MONO_SIL_BIT    6
`define OMVC_AUX_MONO_BIT    2
`define OMVC_BYP_MONO_BIT    1
`define OMVC_DAC_MONO_BIT    0

// slow tick period in master clock cycles (2 to the 21st)
`define OMVC_SLOW_DIV        32'h0020_0000

// audio arithmetic: -10 dB as 81/256, gain steps in q8
`define OMVC_ATTN_MULT       36'h0_0000_0051
`define OMVC_Q_SHIFT         8
`define OMVC_GAIN_OFFSET     7'h03
`define OMVC_STEPS_PER_OCT   7'h06
`define OMVC_GAIN_SHIFT      18
`define OMVC_STEP0           9'h100
`define OMVC_STEP1           9'h11f
`define OMVC_STEP2           9'h142
`define OMVC_STEP3           9'h16a
`define OMVC_STEP4           9'h196
`define OMVC_STEP5           9'h1c8
`define OMVC_POS_MAX         36'h0_0000_7fff
`define OMVC_NEG_MIN         36'hf_ffff_8000
`define OMVC_REF_LEVEL       16'h0000
`define OMVC_OUT_MAX         16'h7fff
`define OMVC_OUT_MIN         16'h8000
`define OMVC_NBITS_MAX       5'h1f

`endif

// [core/omvc_slow_tick.v]
// slow tick divider for the zero-cross timeout
`timescale 1ns/100ps
`include "omvc_defs.vh"
module omvc_slow_tick #(
  parameter [31:0] DIV = `OMVC_SLOW_DIV
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // control
  input  wire        enable,
  // one-cycle pulse every DIV cycles while enabled
  output reg         tick
);

  reg [31:0] count_q;

  // counter restarts from zero whenever the enable drops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (!enable) begin
      count_q <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (count_q == DIV - 32'h0000_0001) begin
      count_q <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

endmodule

// [core/omvc_zero_cross.v]
// speaker gain update gate: immediate, at zero crossing or on timeout tick
`timescale 1ns/100ps
`include "omvc_defs.vh"
module omvc_zero_cross (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // control
  input  wire        zc_en,
  input  wire        gain_wr,
  input  wire [5:0]  gain_wdata,
  input  wire        timeout_tick,
  // speaker mixer samples
  input  wire        mix_valid,
  input  wire        mix_sign,
  // state
  output reg  [5:0]  gain_q,
  output reg         pending_q
);

  reg        last_sign_q;
  reg        have_q;
  reg  [5:0] pend_val_q;
  wire       crossing;

  // sign change between consecutive samples
  assign crossing = mix_valid && have_q && (mix_sign != last_sign_q);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_sign_q <= 1'b0;
      have_q      <= 1'b0;
    end else if (mix_valid) begin
      last_sign_q <= mix_sign;
      have_q      <= 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_q     <= `OMVC_RST_GAIN;
      pend_val_q <= `OMVC_RST_GAIN;
      pending_q  <= 1'b0;
    end else if (gain_wr && !zc_en) begin
      gain_q    <= gain_wdata;
      pending_q <= 1'b0;
    end else if (gain_wr) begin
      // a newer write replaces the held value and wins over a same-cycle event
      pend_val_q <= gain_wdata;
      pending_q  <= 1'b1;
    end else if (pending_q && (!zc_en || crossing || timeout_tick)) begin
      gain_q    <= pend_val_q;
      pending_q <= 1'b0;
    end
  end

endmodule

// [sim/omvc_checker.sv]
// concurrent checks on the ports of the output mixer and speaker volume block
`timescale 1ns/100ps
module omvc_checker (
  // clock and reset
  input wire        ref_clk,
  input wire        rst_b,
  // watched inputs
  input wire        ctl_csb,
  input wire        mono_out_enable,
  input wire        sample_valid,
  // watched outputs
  input wire        out_valid,
  input wire [15:0] speaker_pos_out,
  input wire [15:0] speaker_neg_out,
  input wire [15:0] mono_line_out,
  input wire [5:0]  speaker_gain_now,
  input wire        speaker_gain_pending
);
  // set by the first frame; until then the reset register values must rule the outputs
  reg frame_seen_q;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_seen_q <= 1'b0;
    end else if (!ctl_csb) begin
      frame_seen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    sample_valid;
  endsequence
  sequence s_out;
    ##2 out_valid;
  endsequence
  AST_OUT_LATENCY: assert property (s_take |-> s_out)
    else $error("out_valid missing two cycles after a sample");
  AST_NEG_INVERTS: assert property (out_valid |-> speaker_neg_out ==
    ((speaker_pos_out == 16'h8000) ? 16'h7fff : 16'h0000 - speaker_pos_out))
    else $error("negative speaker output is not the inverse");
  AST_HOLD_BETWEEN: assert property (!out_valid |-> $stable(speaker_pos_out)
    && $stable(speaker_neg_out) && $stable(mono_line_out))
    else $error("outputs moved without out_valid");
  AST_MUTE_AT_RESET: assert property (out_valid && !frame_seen_q |->
    speaker_pos_out == 16'h0000 && mono_line_out == 16'h0000)
    else $error("outputs not at reference before any write");
  AST_MONO_DISABLED: assert property (out_valid && !mono_out_enable &&
    !$past(mono_out_enable) && !$past(mono_out_enable, 2) |-> mono_line_out == 16'h0000)
    else $error("mono output driven while disabled");
  AST_PEND_FROM_WRITE: assert property ($rose(speaker_gain_pending) |->
    !$past(ctl_csb, 2) || !$past(ctl_csb, 3) || !$past(ctl_csb, 4))
    else $error("gain pending without a preceding write");
  AST_GAIN_FROM_CAUSE: assert property (!$stable(speaker_gain_now) |->
    $past(speaker_gain_pending) || !$past(ctl_csb, 3) || !$past(ctl_csb, 4)
    || !$past(ctl_csb, 5) || !$past(ctl_csb, 6))
    else $error("gain changed without write or pending event");
  AST_PEND_HOLDS_GAIN: assert property (speaker_gain_pending &&
    $past(speaker_gain_pending) |-> $stable(speaker_gain_now))
    else $error("gain changed while still pending");
endmodule

bind omvc_top omvc_checker i_omvc_checker (
  .ref_clk              (ref_clk),
  .rst_b                (rst_b),
  .ctl_csb              (ctl_csb),
  .mono_out_enable      (mono_out_enable),
  .sample_valid         (sample_valid),
  .out_valid            (out_valid),
  .speaker_pos_out      (speaker_pos_out),
  .speaker_neg_out      (speaker_neg_out),
  .mono_line_out        (mono_line_out),
  .speaker_gain_now     (speaker_gain_now),
  .speaker_gain_pending (speaker_gain_pending)
);

// [sim/omvc_top_bench.sv]
// self-checking bench for the output mixer and speaker volume block
`timescale 1ns/100ps
`include "omvc_defs.vh"
module omvc_top_bench;
  // short divider keeps the timeout scenario brief
  localparam [31:0] DIV = 32'h0000_0010;
  logic        ref_clk = 1'b0, rst_b = 1'b0, ctl_sclk = 1'b0, ctl_sdin = 1'b0;
  logic        ctl_csb = 1'b1, mono_out_enable = 1'b0, sample_valid = 1'b0;
  logic [15:0] dac_sample = 16'h0000, bypass_sample = 16'h0000, aux_sample = 16'h0000;
  wire         out_valid, speaker_gain_pending;
  wire  [15:0] speaker_pos_out, speaker_neg_out, mono_line_out;
  wire  [5:0]  speaker_gain_now;
  int          err_count = 0, tests_run = 0, cyc = 0, i;
  logic [31:0] seed = 32'h5aa0, r, s;
  logic [8:0]  spk_r, vol_r, mono_r;
  logic [5:0]  gain_r, g;
  longint      st [6] = '{`OMVC_STEP0, `OMVC_STEP1, `OMVC_STEP2,
                          `OMVC_STEP3, `OMVC_STEP4, `OMVC_STEP5};

  omvc_top #(.SLOW_DIV(DIV)) i_omvc_top (
    .ref_clk(ref_clk), .rst_b(rst_b), .ctl_sclk(ctl_sclk), .ctl_sdin(ctl_sdin),
    .ctl_csb(ctl_csb), .mono_out_enable(mono_out_enable), .sample_valid(sample_valid),
    .dac_sample(dac_sample), .bypass_sample(bypass_sample), .aux_sample(aux_sample),
    .out_valid(out_valid), .speaker_pos_out(speaker_pos_out),
    .speaker_neg_out(speaker_neg_out), .mono_line_out(mono_line_out),
    .speaker_gain_now(speaker_gain_now), .speaker_gain_pending(speaker_gain_pending)
  );

  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] sat(input longint v);
    if (v > 32767) return 16'h7fff;
    if (v < -32768) return 16'h8000;
    return v[15:0];
  endfunction
  function automatic longint sx(input logic [15:0] x, input logic on, input logic at);
    longint v;
    v = on ? longint'($signed(x)) : 0;
    return at ? (v * 81) >>> 8 : v;
  endfunction
  function automatic logic [15:0] exp_spk(input logic [15:0] d, b, a);
    longint m;
    m = $signed(sat(sx(d, spk_r[0], 1'b0) + sx(b, spk_r[1], vol_r[8]) + sx(a, spk_r[5], 1'b0)));
    m = (m * st[(gain_r + 3) % 6]) <<< ((gain_r + 3) / 6);
    return vol_r[6] ? 16'h0000 : sat(m >>> 18);
  endfunction
  function automatic logic [15:0] exp_mono(input logic [15:0] d, b, a);
    if (mono_r[6] || !mono_out_enable) return 16'h0000;
    return sat(sx(d, mono_r[0], 1'b0) + sx(b, mono_r[1], mono_r[7]) + sx(a, mono_r[2], 1'b0));
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
    tests_run++;
    if (y !== x) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // every sclk level is held at least two cycles, csb stays low over the whole frame, the fastest the port must accept
  task automatic send(input logic [6:0] ad, input logic [8:0] dt);
    logic [15:0] w;
    w = {ad, dt};
    ctl_csb <= 1'b0;
    for (int k = 15; k >= 0; k--) begin
      ctl_sdin <= w[k];
      ctl_sclk <= 1'b0;
      tick(2);
      ctl_sclk <= 1'b1;
      tick(2);
    end
    ctl_csb <= 1'b1;
    tick(2);
    ctl_sclk <= 1'b0;
    tick(4);
  endtask
  task automatic wr_vol(input logic [8:0] dt);
    send(`OMVC_ADDR_SPK_VOL, dt);
    vol_r = dt;
  endtask
  task automatic gchk(input logic p);
    @(negedge ref_clk);
    chk("pending", {15'h0000, p}, {15'h0000, speaker_gain_pending});
    chk("gain", {10'h000, gain_r}, {10'h000, speaker_gain_now});
    @(posedge ref_clk);
  endtask
  task automatic smp(input logic [15:0] d, b, a, input logic cmp);
    sample_valid <= 1'b1;
    dac_sample <= d;
    bypass_sample <= b;
    aux_sample <= a;
    tick(1);
    sample_valid <= 1'b0;
    tick(2);
    @(negedge ref_clk);
    if (cmp) begin
      chk("speaker", exp_spk(d, b, a), speaker_pos_out);
      chk("mono", exp_mono(d, b, a), mono_line_out);
    end
    @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    tick(10);
    rst_b <= 1'b1;
    tick(3);
    spk_r = `OMVC_RST_SPK_MIX;
    vol_r = `OMVC_RST_SPK_VOL;
    mono_r = `OMVC_RST_MONO_MIX;
    gain_r = `OMVC_RST_GAIN;
    gchk(1'b0);
    mono_out_enable <= 1'b1;
    smp(16'h4000, 16'h4000, 16'h4000, 1'b1);
    wr_vol(9'h039);
    smp(16'h4000, 16'h4000, 16'h4000, 1'b1);
    $display("test reset done");
    for (i = 0; i < 14; i++) begin
      r = rnd();
      s = rnd();
      spk_r = r[8:0] & 9'h023;
      mono_r = r[17:9] & 9'h0c7;
      g = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : r[23:18];
      mono_out_enable <= r[24];
      send(`OMVC_ADDR_SPK_MIX, spk_r);
      send(`OMVC_ADDR_MONO_MIX, mono_r);
      wr_vol({r[25], 1'b0, i % 5 == 4, g});
      gain_r = g;
      gchk(1'b0);
      r = (i == 0) ? 32'h7fff_7fff : (i == 1) ? 32'h8000_8000 : rnd();
      smp(r[15:0], r[31:16], s[15:0], 1'b1);
    end
    $display("test random done");
    // start from a positive mix so the next positive sample is no crossing
    spk_r = 9'h001;
    send(`OMVC_ADDR_SPK_MIX, spk_r);
    wr_vol(9'h0b9);
    gain_r = 6'h39;
    smp(16'h1000, 16'h0000, 16'h0000, 1'b1);
    wr_vol(9'h0a0);
    gchk(1'b1);
    wr_vol(9'h0bf);
    tick(40);
    gchk(1'b1);
    smp(16'h1000, 16'h0000, 16'h0000, 1'b1);
    smp(16'hf000, 16'h0000, 16'h0000, 1'b0);
    tick(3);
    gain_r = 6'h3f;
    gchk(1'b0);
    smp(16'hf000, 16'h0000, 16'h0000, 1'b1);
    $display("test zero cross done");
    wr_vol(9'h0a0);
    gchk(1'b1);
    send(`OMVC_ADDR_ADD_CTRL, 9'h001);
    tick(DIV + 4);
    gain_r = 6'h20;
    gchk(1'b0);
    smp(16'hf000, 16'h0000, 16'h0000, 1'b1);
    $display("test timeout done");
    send(`OMVC_ADDR_ADD_CTRL, 9'h000);
    wr_vol(9'h0a5);
    gchk(1'b1);
    wr_vol(9'h02a);
    gain_r = 6'h2a;
    gchk(1'b0);
    smp(16'h1000, 16'h0000, 16'h0000, 1'b1);
    $display("test zero cross clear done");
    finish_test();
  end
endmodule
